// >>> logic/sfo_pkg.sv
/*
  Shared constants and types for the framed serial port core: control and
  status bit positions, timing counts, the core state and the pin bundles.
  Assumes a single 20 MHz core clock; every slower rate is derived from it.
*/
package sfo_pkg;

  // Character width and transmit buffer depth.
  localparam int CHAR_BITS = 16;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CHAR_BITS-1:0] ZERO_WORD = 16'h0000;

  // Timing: core clock and the serial clock made when the core is clock master.
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_PERIOD_NS = 400;
  localparam int SCK_HALF_RAW = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SCK_HALF_CYC = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);

  // Control register bit positions.
  localparam int CTL_FRAME_EN = 31;
  localparam int CTL_FRAME_DIR = 30;
  localparam int CTL_FRAME_POL = 29;
  localparam int CTL_FRAME_PW = 27;
  localparam int CTL_FRAME_CNT_HI = 26;
  localparam int CTL_FRAME_CNT_LO = 24;
  localparam int CTL_ENH_BUF = 16;
  localparam int CTL_ON = 15;
  localparam int CTL_SDO_DIS = 12;
  localparam int CTL_CLK_PHASE = 8;
  localparam int CTL_SS_EN = 7;
  localparam int CTL_CLK_POL = 6;
  localparam int CTL_CLK_MASTER = 5;

  // Status register bit positions.
  localparam int STS_RX_FULL = 0;
  localparam int STS_TX_EMPTY = 3;
  localparam int STS_RX_OVF = 6;

  // Index of each synchronised pin.
  localparam int PIN_SCK = 0;
  localparam int PIN_FRM = 1;
  localparam int PIN_SDI = 2;
  localparam int NUM_PINS = 3;

  typedef enum logic [1:0] {
    SFO_IDLE = 2'b00,
    SFO_FSYNC = 2'b01,
    SFO_SHIFT = 2'b10
  } sfo_state_e;

  typedef struct packed {
    logic sck;
    logic frame;
    logic sdi;
  } sfo_pin_in_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic frame;
    logic frame_oe;
    logic sdo;
    logic sdo_oe;
  } sfo_pin_out_t;

  typedef struct packed {
    logic [NUM_PINS-1:0][2:0] sync;
    logic [NUM_PINS-1:0] lvl;
    sfo_state_e st;
    logic [DIV_W-1:0] div;
    logic sck;
    logic [CNT_W-1:0] samp_cnt;
    logic [CNT_W-1:0] pulse_left;
    logic [2:0] chars_left;
    logic [CHAR_BITS-1:0] tx_sr;
    logic [CHAR_BITS-1:0] rx_sr;
    logic [CHAR_BITS-1:0] rx_buf;
    logic rx_full;
    logic ovf;
    logic irq;
    logic armed;
    sfo_pin_out_t pins;
  } sfo_core_t;

endpackage : sfo_pkg

// >>> logic/sfo_fifo.sv
/*
  Transmit word FIFO with valid and ready on both sides.
  Assumes the reader pops only while out_valid_o is high; a write while
  in_ready_o is low is ignored.
*/
`timescale 1ns/1ps
module sfo_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // Core clock.
  input wire logic rst_n_i, // Synchronised reset, active low.
  input wire logic limit_one_i, // High: behave as a single-word buffer.
  input wire logic in_valid_i, // Write request.
  input wire logic [WIDTH-1:0] in_data_i, // Write data.
  output logic in_ready_o, // Room for a word.
  output logic out_valid_o, // A word is available.
  output logic [WIDTH-1:0] out_data_o, // Oldest word.
  input wire logic out_ready_i // Pop the oldest word.
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
  } sfo_fifo_t;

  sfo_fifo_t cur_ff;
  sfo_fifo_t nxt_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid_i && cur_ff.in_ready;
  assign pop = out_ready_i && cur_ff.out_valid;
  assign in_ready_o = cur_ff.in_ready;
  assign out_valid_o = cur_ff.out_valid;
  assign out_data_o = mem[cur_ff.rd];

  always_comb begin
    nxt_state = cur_ff;
    if (push) begin
      nxt_state.wr = (cur_ff.wr == AW'(DEPTH - 1)) ? '0 : cur_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_state.rd = (cur_ff.rd == AW'(DEPTH - 1)) ? '0 : cur_ff.rd + 1'b1;
    end
    nxt_state.count = cur_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    // Ready is registered so that the writer sees a flop, not a comparator.
    nxt_state.in_ready = limit_one_i ? (nxt_state.count == '0)
                                     : (nxt_state.count != (AW+1)'(DEPTH));
    nxt_state.out_valid = (nxt_state.count != '0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[cur_ff.wr] <= in_data_i;
    end
  end

endmodule : sfo_fifo

// >>> logic/sfo_core.sv
/*
  Framed serial port core: transmit FIFO, shifter, receive buffer with
  overflow handling, receive-only output disable and frame sync generation
  or detection, with the serial clock made here or taken from the pin.
  Assumes control bits are held stable while the port is on, and that the
  pin inputs are asynchronous to mclk_i and slower than a quarter of it.
*/
// Notes on behaviour
// - New word finishing while receive buffer unread sets overflow flag, status bit 6.
// - On overflow the new word is dropped; the unread older word stays.
// - Overflow blocks further reception; only software clears it.
// - Output-disable bit 12 releases the serial data output pin in every mode.
// - Frame enable bit 31 makes select pin a frame pulse; select-enable ignored.
// - Frame direction bit 30: zero drives the pulse, one receives it.
// - Frame polarity bit 29 sets the active level, driven and sampled.
// - Pulse width bit 27 stretches the frame pulse to one character.
// - Frame count field 26:24 sets characters per frame pulse.
// - Framing works with clock master and clock slave, all four combinations.
// - Buffer select bit 16 still picks single-word or eight-word buffering.
// - Framed clock master drives a free-running serial clock.
// - Framed mode: clock polarity bit 6 applies, clock phase bit 8 ignored.
// - XOR zero: outputs change on rising edges, input sampled on falling.
// - XOR one: outputs change on falling edges, input sampled on rising.
// - Frame master starts a pulse on data write, loads shifter when pulse ends.
// - Frame slave loads shifter and starts when an active pulse is sampled.
// - A received pulse always starts a transfer; zeros go out without data.
// - Frame master asserts pulse on next transmit edge, data on the edge that ends the pulse.
// - Frame slave samples pulse on sample edge, transmits next edge, flags done.
`timescale 1ns/1ps
module sfo_core (
  input wire logic mclk_i, // Core clock, 20 MHz.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic [31:0] control_register_i, // Control bits.
  input wire logic tx_write_i, // Write a word to the transmit buffer.
  input wire logic [sfo_pkg::CHAR_BITS-1:0] tx_data_i, // Word to transmit.
  output logic tx_ready_o, // Transmit buffer can take a word.
  input wire logic rx_read_i, // Software has read the receive buffer.
  output logic [sfo_pkg::CHAR_BITS-1:0] rx_data_o, // Receive buffer.
  input wire logic ovf_clear_i, // Clear the overflow flag.
  input wire logic irq_clear_i, // Clear the transfer flag.
  output logic transfer_irq_flag_o, // Sticky character-done flag.
  output logic [31:0] status_register_o, // Status bits.
  input wire sfo_pkg::sfo_pin_in_t pins_i, // Pin input levels.
  output sfo_pkg::sfo_pin_out_t pins_o // Pin drive levels and enables.
);

  // Drive level for an active or idle frame pulse, and test of a sensed level.
  function automatic logic sfo_frame_level(input logic act, input logic pol);
    sfo_frame_level = ~(act ^ pol);
  endfunction : sfo_frame_level

  logic [1:0] rst_sync_ff;
  logic rst_n;
  sfo_pkg::sfo_core_t cur_ff;
  sfo_pkg::sfo_core_t nxt_state;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [sfo_pkg::CHAR_BITS-1:0] fifo_data;
  logic pop;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  sfo_fifo #(
    .WIDTH(sfo_pkg::CHAR_BITS),
    .DEPTH(sfo_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .limit_one_i(~control_register_i[sfo_pkg::CTL_ENH_BUF]),
    .in_valid_i(tx_write_i),
    .in_data_i(tx_data_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(pop)
  );

  assign tx_ready_o = fifo_in_ready;
  assign rx_data_o = cur_ff.rx_buf;
  assign transfer_irq_flag_o = cur_ff.irq;
  assign pins_o = cur_ff.pins;

  always_comb begin
    status_register_o = 32'h0000_0000;
    status_register_o[sfo_pkg::STS_RX_FULL] = cur_ff.rx_full;
    status_register_o[sfo_pkg::STS_TX_EMPTY] = ~fifo_valid;
    status_register_o[sfo_pkg::STS_RX_OVF] = cur_ff.ovf;
  end

  always_comb begin
    logic on;
    logic framed;
    logic fmaster;
    logic fslave;
    logic master;
    logic pol;
    logic out_on_fall;
    logic run;
    logic tick;
    logic rise;
    logic fall;
    logic rise_s;
    logic fall_s;
    logic tx_edge;
    logic smp_edge;
    logic frame_seen;
    logic load;
    logic new_frame;
    logic [sfo_pkg::CHAR_BITS-1:0] word;
    logic [2:0] pin_vec;
    logic [2:0] frame_cnt;

    nxt_state = cur_ff;
    pop = 1'b0;
    load = 1'b0;
    new_frame = 1'b0;
    word = sfo_pkg::ZERO_WORD;
    on = control_register_i[sfo_pkg::CTL_ON];
    // The select-enable bit is never looked at while framing.
    framed = control_register_i[sfo_pkg::CTL_FRAME_EN];
    fmaster = framed && !control_register_i[sfo_pkg::CTL_FRAME_DIR];
    fslave = framed && control_register_i[sfo_pkg::CTL_FRAME_DIR];
    master = control_register_i[sfo_pkg::CTL_CLK_MASTER];
    pol = control_register_i[sfo_pkg::CTL_FRAME_POL];
    frame_cnt = control_register_i[sfo_pkg::CTL_FRAME_CNT_HI:sfo_pkg::CTL_FRAME_CNT_LO];
    // Phase only matters outside framing.
    out_on_fall = control_register_i[sfo_pkg::CTL_CLK_POL] ^
                  (control_register_i[sfo_pkg::CTL_CLK_PHASE] && !framed);

    // Three-stage synchronisers; a level counts once stages two and three agree.
    pin_vec = '0;
    pin_vec[sfo_pkg::PIN_SCK] = pins_i.sck;
    pin_vec[sfo_pkg::PIN_FRM] = pins_i.frame;
    pin_vec[sfo_pkg::PIN_SDI] = pins_i.sdi;
    for (int i = 0; i < sfo_pkg::NUM_PINS; i++) begin
      nxt_state.sync[i] = {cur_ff.sync[i][1:0], pin_vec[i]};
      if (cur_ff.sync[i][1] == cur_ff.sync[i][2]) begin
        nxt_state.lvl[i] = cur_ff.sync[i][2];
      end
    end

    // Own serial clock: free-running while framed, else only around a transfer.
    run = on && master && (framed || cur_ff.st != sfo_pkg::SFO_IDLE || fifo_valid);
    tick = run && (cur_ff.div == sfo_pkg::DIV_LAST);
    if (!run) begin
      nxt_state.div = '0;
      nxt_state.sck = control_register_i[sfo_pkg::CTL_CLK_POL];
    end else if (tick) begin
      nxt_state.div = '0;
      nxt_state.sck = ~cur_ff.sck;
    end else begin
      nxt_state.div = cur_ff.div + 1'b1;
    end

    // As clock slave the partner's clock is assumed to run on its own.
    if (master) begin
      rise = tick && !cur_ff.sck;
      fall = tick && cur_ff.sck;
      // Returning data needs the pin delay plus the synchroniser, so the sample
      // waits one cycle past our own edge; at this clock ratio that is all the margin.
      rise_s = run && (cur_ff.div == '0) && cur_ff.sck;
      fall_s = run && (cur_ff.div == '0) && !cur_ff.sck;
    end else begin
      rise = nxt_state.lvl[sfo_pkg::PIN_SCK] && !cur_ff.lvl[sfo_pkg::PIN_SCK];
      fall = !nxt_state.lvl[sfo_pkg::PIN_SCK] && cur_ff.lvl[sfo_pkg::PIN_SCK];
      rise_s = rise;
      fall_s = fall;
    end
    tx_edge = on && (out_on_fall ? fall : rise);
    smp_edge = on && (out_on_fall ? rise_s : fall_s);
    frame_seen = fslave && smp_edge &&
                 sfo_frame_level(nxt_state.lvl[sfo_pkg::PIN_FRM], pol);

    // Software clears come first so that a hardware set in the same cycle wins.
    if (rx_read_i) begin
      nxt_state.rx_full = 1'b0;
    end
    if (ovf_clear_i) begin
      nxt_state.ovf = 1'b0;
    end
    if (irq_clear_i) begin
      nxt_state.irq = 1'b0;
    end
    if (frame_seen) begin
      nxt_state.armed = 1'b1;
    end

    // Outside a pulse the frame pin rests at the inactive level of the polarity.
    if (cur_ff.st != sfo_pkg::SFO_FSYNC) begin
      nxt_state.pins.frame = sfo_frame_level(1'b0, pol);
    end

    case (cur_ff.st)
      sfo_pkg::SFO_IDLE: begin
        if (tx_edge && fslave && cur_ff.armed) begin
          new_frame = 1'b1;
        end else if (tx_edge && fmaster && fifo_valid) begin
          nxt_state.pins.frame = sfo_frame_level(1'b1, pol);
          nxt_state.pulse_left = control_register_i[sfo_pkg::CTL_FRAME_PW] ?
                                 sfo_pkg::CNT_W'(sfo_pkg::CHAR_BITS - 1) : '0;
          nxt_state.chars_left = frame_cnt;
          nxt_state.st = sfo_pkg::SFO_FSYNC;
        end else if (tx_edge && !framed && fifo_valid) begin
          load = 1'b1;
          nxt_state.chars_left = 3'h0;
        end
      end
      sfo_pkg::SFO_FSYNC: begin
        if (tx_edge) begin
          if (cur_ff.pulse_left == '0) begin
            nxt_state.pins.frame = sfo_frame_level(1'b0, pol);
            load = 1'b1;
          end else begin
            nxt_state.pulse_left = cur_ff.pulse_left - 1'b1;
          end
        end
      end
      sfo_pkg::SFO_SHIFT: begin
        if (smp_edge && cur_ff.samp_cnt != sfo_pkg::CNT_W'(sfo_pkg::CHAR_BITS)) begin
          nxt_state.rx_sr = {cur_ff.rx_sr[sfo_pkg::CHAR_BITS-2:0],
                             nxt_state.lvl[sfo_pkg::PIN_SDI]};
          nxt_state.samp_cnt = cur_ff.samp_cnt + 1'b1;
          if (cur_ff.samp_cnt == sfo_pkg::CNT_W'(sfo_pkg::CHAR_BITS - 1)) begin
            nxt_state.irq = 1'b1;
            // An unread word or a pending overflow keeps the buffer untouched.
            if (cur_ff.ovf) begin
              nxt_state.ovf = 1'b1;
            end else if (nxt_state.rx_full) begin
              nxt_state.ovf = 1'b1;
            end else begin
              nxt_state.rx_buf = {cur_ff.rx_sr[sfo_pkg::CHAR_BITS-2:0],
                                  nxt_state.lvl[sfo_pkg::PIN_SDI]};
              nxt_state.rx_full = 1'b1;
            end
          end
        end
        if (tx_edge) begin
          if (cur_ff.samp_cnt == sfo_pkg::CNT_W'(sfo_pkg::CHAR_BITS)) begin
            if (fslave && (cur_ff.armed || frame_seen)) begin
              new_frame = 1'b1;
            end else if (cur_ff.chars_left != 3'h0) begin
              nxt_state.chars_left = cur_ff.chars_left - 1'b1;
              load = 1'b1;
            end else begin
              nxt_state.st = sfo_pkg::SFO_IDLE;
            end
          end else begin
            nxt_state.pins.sdo = cur_ff.tx_sr[sfo_pkg::CHAR_BITS-1];
            nxt_state.tx_sr = {cur_ff.tx_sr[sfo_pkg::CHAR_BITS-2:0], 1'b0};
          end
        end
      end
      default: begin
        nxt_state.st = sfo_pkg::SFO_IDLE;
      end
    endcase

    if (new_frame) begin
      nxt_state.armed = 1'b0;
      nxt_state.chars_left = frame_cnt;
      load = 1'b1;
    end
    // An empty buffer at load time sends a zero word.
    if (load) begin
      pop = fifo_valid;
      word = fifo_valid ? fifo_data : sfo_pkg::ZERO_WORD;
      nxt_state.pins.sdo = word[sfo_pkg::CHAR_BITS-1];
      nxt_state.tx_sr = {word[sfo_pkg::CHAR_BITS-2:0], 1'b0};
      nxt_state.samp_cnt = '0;
      nxt_state.st = sfo_pkg::SFO_SHIFT;
    end

    nxt_state.pins.sck = cur_ff.sck;
    nxt_state.pins.sck_oe = on && master;
    nxt_state.pins.frame_oe = on && fmaster;
    nxt_state.pins.sdo_oe = on && !control_register_i[sfo_pkg::CTL_SDO_DIS];

    // Turning the port off aborts any transfer; sticky flags stay for software.
    if (!on) begin
      nxt_state.st = sfo_pkg::SFO_IDLE;
      nxt_state.armed = 1'b0;
      nxt_state.samp_cnt = '0;
      nxt_state.pins.frame = sfo_frame_level(1'b0, pol);
      pop = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end

endmodule : sfo_core

// >>> tb/sfo_core_props.sv
/*
  Concurrent checks on the ports of the framed serial core.
  Assumes control bits change only while reset is applied.
*/
`timescale 1ns/1ps
module sfo_core_props (
  input wire logic mclk_i, // Core clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic [31:0] control_register_i, // Control bits.
  input wire logic ovf_clear_i, // Overflow clear.
  input wire logic irq_clear_i, // Flag clear.
  input wire logic transfer_irq_flag_o, // Character flag.
  input wire logic [31:0] status_register_o, // Status bits.
  input wire logic [sfo_pkg::CHAR_BITS-1:0] rx_data_o, // Receive buffer.
  input wire sfo_pkg::sfo_pin_out_t pins_o // Pin drive.
);
  wire logic [31:0] c;
  wire logic ovf;
  wire logic act;
  assign c = control_register_i;
  assign ovf = status_register_o[6];
  // Only the one-clock pulse width is judged, so the stretched setting is excluded.
  assign act = c[31] && !c[30] && !c[27] && pins_o.frame_oe && (pins_o.frame == c[29]);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_sck_master;
    c[31] && c[5] && c[15] && pins_o.sck_oe;
  endsequence
  sequence s_pulse_body;
    act [*8] ##1 !act;
  endsequence
  a_ovf_sticky: assert property (ovf && !ovf_clear_i |=> ovf)
    else $error("overflow flag dropped without a clear");
  a_ovf_keeps_word: assert property (ovf |=> $stable(rx_data_o))
    else $error("receive buffer changed while overflowed");
  a_ovf_needs_full: assert property ($rose(ovf) |-> $past(status_register_o[0]))
    else $error("overflow without a full receive buffer");
  a_sdo_released: assert property (c[12] && $past(c[12]) |-> !pins_o.sdo_oe)
    else $error("data output driven while disabled");
  a_frame_input: assert property (c[31] && c[30] && $past(c[31] && c[30]) |-> !pins_o.frame_oe)
    else $error("frame pin driven as frame slave");
  a_sck_input: assert property (c[31] && !c[5] && $past(c[31] && !c[5]) |-> !pins_o.sck_oe)
    else $error("clock pin driven as clock slave");
  a_sck_free_run: assert property (s_sck_master [*2] |-> ##[1:4] $changed(pins_o.sck))
    else $error("framed master clock stopped");
  a_pulse_one_clock: assert property ($rose(act) |-> s_pulse_body)
    else $error("frame pulse not one serial clock long");
  a_irq_sticky: assert property (transfer_irq_flag_o && !irq_clear_i |=> transfer_irq_flag_o)
    else $error("transfer flag dropped without a clear");
  a_irq_with_data: assert property ($rose(transfer_irq_flag_o) |-> status_register_o[0] || ovf)
    else $error("transfer flag without received word");
endmodule : sfo_core_props

// >>> tb/sfo_peer.sv
/*
  Far-side peripheral model: free-running clock, frame pulses, 16-bit words.
  Assumes it owns the clock and frame lines whenever the core releases them.
*/
`timescale 1ns/1ps
module sfo_peer (
  input wire logic run_i, // Drive the serial clock.
  input wire logic pol_i, // Clock idle level.
  input wire logic fpol_i, // Frame active level.
  input wire logic pulse_i, // Rise requests one frame pulse.
  input wire logic [3:0] n_i, // Characters per frame.
  input wire logic [15:0] word_i, // Word sent on the data line.
  input wire sfo_pkg::sfo_pin_out_t dut_i, // Core drive.
  output sfo_pkg::sfo_pin_in_t line_o, // Resolved lines.
  output logic [15:0] got_o, // Last word captured.
  output int chars_o // Characters captured.
);
  logic sck = 1'h0;
  logic fact = 1'h0;
  logic sdi = 1'h0;
  logic go = 1'h0;
  logic [15:0] sh = 16'h0000;
  int req = 0;
  int txn = 0;
  int rxn = 0;
  assign line_o.sck = dut_i.sck_oe ? dut_i.sck : sck;
  assign line_o.frame = dut_i.frame_oe ? dut_i.frame : ~(fpol_i ^ fact);
  assign line_o.sdi = sdi;
  initial begin
    got_o = 16'h0000;
    chars_o = 0;
    #37;
    forever #200 sck = run_i ? ~sck : pol_i;
  end
  always @(posedge pulse_i) req = 1;
  task automatic drive();
    fact = (req == 1);
    req = (req == 1) ? 2 : 0;
    if (go) begin
      sh = word_i;
      txn = 16;
      go = 1'h0;
    end
    if (txn > 0) begin
      sdi = sh[15];
      sh = {sh[14:0], 1'h0};
      txn--;
    end else begin
      // A released line toggles so that no stale bit can pass for data.
      sdi = ~sdi;
    end
  endtask : drive
  task automatic sample();
    if (rxn > 0) begin
      got_o = {got_o[14:0], dut_i.sdo_oe ? dut_i.sdo : ~got_o[0]};
      rxn--;
      if (rxn % 16 == 0) chars_o++;
    end else if (line_o.frame === fpol_i) begin
      rxn = 16 * int'(n_i);
      go = 1'h1;
    end
  endtask : sample
  always @(posedge line_o.sck) if (pol_i) sample(); else drive();
  always @(negedge line_o.sck) if (pol_i) drive(); else sample();
endmodule : sfo_peer

// >>> tb/sfo_core_tb.sv
/*
  Self-checking bench for the framed serial core with its far-side model.
  Assumes the core and package are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("unexpected %s: expected %h, seen %h", n, e, g); \
    end \
  end
module sfo_core_tb;
  typedef struct packed {
    logic ms, fs, fp, cp, wr, dis;
    logic [15:0] d, p;
  } sfo_row_t;
  // Rows: clock master, frame slave, frame level, clock level, write, output off, words.
  localparam logic [37:0] ROWS [6] = '{{6'h2A, 16'hA5C3, 16'h3C5A}, {6'h36, 16'h8001, 16'h7FFE},
    {6'h02, 16'h1234, 16'hFEDC}, {6'h1E, 16'hC0DE, 16'h0F0F}, {6'h38, 16'h0000, 16'h5555},
    {6'h27, 16'hFFFF, 16'h9669}};
  logic mclk_i = 1'h0, reset_n_i = 1'h0, tx_write_i = 1'h0, rx_read_i = 1'h0;
  logic ovf_clear_i = 1'h0, irq_clear_i = 1'h0, tx_ready_o, transfer_irq_flag_o;
  logic [31:0] ctrl = 32'h0000_0000, status_register_o;
  logic [15:0] tx_data_i = 16'h0000, rx_data_o, pword = 16'h0000, got;
  logic run = 1'h0, pol = 1'h0, fpol = 1'h1, fpul = 1'h0;
  logic [3:0] n = 4'h1;
  sfo_pkg::sfo_pin_in_t pins_i;
  sfo_pkg::sfo_pin_out_t pins_o;
  wire logic [1:0] flg;
  int chars, c0, acc, fails = 0, num_checks = 0;
  sfo_row_t r;
  assign flg = {status_register_o[6], transfer_irq_flag_o};
  sfo_core dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .control_register_i(ctrl),
    .tx_write_i(tx_write_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
    .rx_read_i(rx_read_i), .rx_data_o(rx_data_o), .ovf_clear_i(ovf_clear_i),
    .irq_clear_i(irq_clear_i), .transfer_irq_flag_o(transfer_irq_flag_o),
    .status_register_o(status_register_o), .pins_i(pins_i), .pins_o(pins_o));
  sfo_peer u_peer (.run_i(run), .pol_i(pol), .fpol_i(fpol), .pulse_i(fpul), .n_i(n),
    .word_i(pword), .dut_i(pins_o), .line_o(pins_i), .got_o(got), .chars_o(chars));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic tick();
    @(posedge mclk_i);
    #2;
  endtask : tick
  task automatic wr(input logic [15:0] w);
    tx_data_i = w;
    tx_write_i = 1'h1;
    tick();
    tx_write_i = 1'h0;
    tick();
  endtask : wr
  task automatic fpulse();
    fpul = 1'h1;
    tick();
    fpul = 1'h0;
    tick();
  endtask : fpulse
  task automatic clr(input logic all);
    irq_clear_i = 1'h1;
    ovf_clear_i = all;
    rx_read_i = all;
    tick();
    {irq_clear_i, ovf_clear_i, rx_read_i} = 3'h0;
    tick();
  endtask : clr
  // Phase and select-enable are set on purpose: framing must ignore both.
  task automatic cfg(input logic ms, fs, fp, cp, input logic [2:0] cnt, input logic enh, dis);
    reset_n_i = 1'h0;
    ctrl = {1'h1, fs, fp, 2'h0, cnt, 7'h00, enh, 1'h1, 2'h0, dis, 3'h0, 2'h3, cp, ms, 5'h00};
    {run, pol, fpol} = {~ms, cp, fp};
    n = {1'h0, cnt} + 4'h1;
    repeat (3) tick();
    reset_n_i = 1'h1;
    repeat (4) tick();
  endtask : cfg
  task automatic wait_hi(input int b);
    int i;
    for (i = 0; i < 4000 && flg[b] !== 1'h1; i++) tick();
    if (i == 4000) `CHK("flag wait", 1'h1, flg[b])
  endtask : wait_hi
  task automatic wait_chars(input int k);
    int i;
    for (i = 0; i < 8000 && chars < k; i++) tick();
    if (i == 8000) `CHK("character wait", k, chars)
  endtask : wait_chars
  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    #1_000_000;
    fails++;
    $display("unexpected timeout: tests did not finish");
    summarize();
  end
  initial begin
    repeat (3) tick();
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      cfg(r.ms, r.fs, r.fp, r.cp, 3'h0, 1'h0, r.dis);
      pword = r.p;
      c0 = chars;
      if (r.wr) wr(r.d);
      if (r.fs) fpulse();
      wait_chars(c0 + 1);
      wait_hi(0);
      `CHK("receive word", r.p, rx_data_o)
      if (r.dis) `CHK("output enable", 1'h0, pins_o.sdo_oe)
      else `CHK("line word", r.wr ? r.d : 16'h0000, got)
    end
    $display("test mode rows done");
    cfg(1'h1, 1'h0, 1'h1, 1'h0, 3'h0, 1'h0, 1'h0);
    pword = 16'hA1A1;
    wr(16'h0101);
    wait_hi(0);
    clr(1'h0);
    pword = 16'hB2B2;
    wr(16'h0202);
    wait_hi(1);
    `CHK("overflow set", 1'h1, status_register_o[6])
    `CHK("kept word", 16'hA1A1, rx_data_o)
    clr(1'h0);
    wr(16'h0303);
    wait_hi(0);
    `CHK("overflow held", 1'h1, status_register_o[6])
    `CHK("still kept", 16'hA1A1, rx_data_o)
    clr(1'h1);
    `CHK("overflow cleared", 1'h0, status_register_o[6])
    pword = 16'hD4D4;
    wr(16'h0404);
    wait_hi(0);
    `CHK("word after clear", 16'hD4D4, rx_data_o)
    $display("test overflow done");
    cfg(1'h1, 1'h0, 1'h1, 1'h0, 3'h2, 1'h1, 1'h0);
    c0 = chars;
    wr(16'h5A5A);
    wait_chars(c0 + 3);
    `CHK("characters per pulse", c0 + 3, chars)
    `CHK("empty buffer word", 16'h0000, got)
    $display("test frame count done");
    for (int e = 0; e < 2; e++) begin
      cfg(1'h1, 1'h1, 1'h0, 1'h1, 3'h7, e[0], 1'h0);
      acc = 0;
      for (int i = 0; i < 10; i++) begin
        if (tx_ready_o === 1'h1) acc++;
        wr(16'h1000 | 16'(i));
      end
      `CHK("buffer depth", e ? 8 : 1, acc)
      `CHK("buffer refuses", 1'h0, tx_ready_o)
    end
    c0 = chars;
    repeat (40) tick();
    fpulse();
    wait_chars(c0 + 8);
    wait_hi(0);
    `CHK("last drained word", 16'h1007, got)
    `CHK("buffer empty", 1'h1, status_register_o[3])
    $display("test buffering done");
    summarize();
  end
endmodule : sfo_core_tb
bind sfo_core sfo_core_props u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .control_register_i(control_register_i), .ovf_clear_i(ovf_clear_i),
  .irq_clear_i(irq_clear_i), .transfer_irq_flag_o(transfer_irq_flag_o),
  .status_register_o(status_register_o), .rx_data_o(rx_data_o), .pins_o(pins_o));
